/* design/dpm_map.vh */
// Register offsets, field positions, reset values and timing counts
// for the drive protection and maintenance block.
// Assumes a 25 MHz controller clock.
`ifndef DPM_MAP_VH
`define DPM_MAP_VH

// Register offsets (word addresses on the plain register port)
`define DPM_OFS_OPTION 4'h0
`define DPM_OFS_HIST_CLR 4'h1
`define DPM_OFS_FB_TIMEOUT 4'h2
`define DPM_OFS_FUNC_SEL 4'h3
`define DPM_OFS_FAN_CTRL 4'h4
`define DPM_OFS_RT_PRESET 4'h5
`define DPM_OFS_RUNTIME 4'h6
`define DPM_OFS_STATUS 4'h7

// Option word bit positions
`define DPM_OPT_CARRIER 0
`define DPM_OPT_IN_PHASE 1
`define DPM_OPT_OUT_PHASE 2
`define DPM_OPT_CAP_USER 3
`define DPM_OPT_CAP_JUDGE 4
`define DPM_OPT_FAN_CONT 5

// Reset values
`define DPM_RST_OPTION 6'h00
`define DPM_RST_FB_TIMEOUT 10'h000
`define DPM_RST_FUNC_SEL 4'h0
`define DPM_RST_FAN_CTRL 1'h0

// Function select code for current-input feedback
`define DPM_SEL_PID_FB 4'h5
// Current threshold in units of 0.01 mA (2 mA)
`define DPM_CUR_MIN 12'h0C8
// Timeout unit is 0.1 s; at 25 MHz that is this many cycles
`define DPM_TENTH_S_NS 100000000
`define DPM_CLK_NS 40
`define DPM_TENTH_S_CYC (`DPM_TENTH_S_NS / `DPM_CLK_NS)
// Largest timeout code, 60.0 s
`define DPM_TIMEOUT_MAX 10'h258

`endif

/* design/dpm_top.v */
// Protection and maintenance configuration logic for a motor drive.
// Assumes synchronous status inputs from the power stage and a keypad
// register port with read data one cycle after the read strobe.
//
// Implementation choices: the address map and the strobed register port.
`default_nettype none
`include "dpm_map.vh"

// Function
// - Timeout 0.1-60.0 s: raise feedback-loss alarm after conditions hold that long.
// - Timeout zero disables feedback-loss detection entirely.
// - Condition: current-input terminal current below 2 mA.
// - Condition: terminal selected as PID feedback (code 5) and PID active.
// - Writing run-time preset loads counter; zero clears it.
// - Run-time preset taken as hexadecimal binary value.
// - Writing 1 to history clear erases alarm history, then reads back 0.
// - Protection option word is six independent bits.
// - Bit 0 enables carrier lowering on overheat or overload.
// - Bit 1 enables input phase-loss trip and alarm.
// - Bit 2 enables output phase-loss trip while running.
// - Bit 3 selects user capacitor-life criterion over factory one.
// - Bit 4 enables capacitor-life judgment by discharge time.
// - Fan lock: bit 5 low trips and coasts; high keeps running.
// - Fan lock always asserts overheat and life-warning outputs.
// - Fan stopped by on/off control reads normal; start commands fan on.
module dpm_top #(
  parameter TENTH_S_CYC = `DPM_TENTH_S_CYC,
  parameter RT_W = 24
) (
  input wire clk,
  input wire reset_n,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire [11:0] current_input_level,
  input wire pid_active,
  input wire run_cmd,
  input wire hour_tick,
  input wire heatsink_hot,
  input wire overload,
  input wire input_phase_loss,
  input wire output_phase_loss,
  input wire fan_locked_raw,
  input wire fan_stop_wanted,
  input wire power_off,
  input wire discharge_short,
  output reg feedback_loss_alarm,
  output reg input_phase_alarm,
  output reg output_phase_alarm,
  output reg fan_lock_alarm,
  output reg drive_stop,
  output reg coast_stop,
  output reg carrier_lower,
  output reg overheat_output,
  output reg life_warning,
  output reg fan_run,
  output reg cap_judge_en,
  output reg cap_user_crit,
  output reg history_clear
);

  reg [5:0] protection_option_word_r;
  reg alarm_history_clear_r;
  reg [9:0] feedback_loss_timeout_r;
  reg [3:0] current_input_function_select_r;
  reg fan_onoff_control_r;
  reg [RT_W-1:0] runtime_r;
  reg [31:0] tenth_cnt_r;
  reg [9:0] tenths_r;
  wire fb_cond;
  wire fan_lock_seen;
  wire fb_trip;
  wire in_phase_set;
  wire out_phase_set;
  wire fan_lock_set;
  reg [31:0] rdata_nxt;
  reg [31:0] tenth_cnt_nxt;
  reg [9:0] tenths_nxt;

  //////////////////////////////////////////////////////////////////////
  // Register port

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      protection_option_word_r <= `DPM_RST_OPTION;
      alarm_history_clear_r <= 1'b0;
      feedback_loss_timeout_r <= `DPM_RST_FB_TIMEOUT;
      current_input_function_select_r <= `DPM_RST_FUNC_SEL;
      fan_onoff_control_r <= `DPM_RST_FAN_CTRL;
      runtime_r <= {RT_W{1'b0}};
      reg_rdata <= 32'h00000000;
      history_clear <= 1'b0;
    end else begin
      // Clear is one-shot; the setting drops back to 0 next cycle
      alarm_history_clear_r <= 1'b0;
      history_clear <= alarm_history_clear_r;
      if (hour_tick && run_cmd)
        runtime_r <= runtime_r + {{(RT_W-1){1'b0}}, 1'b1};
      if (reg_wr) begin
        case (reg_addr)
          `DPM_OFS_OPTION: protection_option_word_r <= reg_wdata[5:0];
          `DPM_OFS_HIST_CLR: alarm_history_clear_r <= reg_wdata[0];
          `DPM_OFS_FB_TIMEOUT: begin
            // Codes beyond 60.0 s are clamped rather than refused
            if (reg_wdata[9:0] > `DPM_TIMEOUT_MAX)
              feedback_loss_timeout_r <= `DPM_TIMEOUT_MAX;
            else
              feedback_loss_timeout_r <= reg_wdata[9:0];
          end
          `DPM_OFS_FUNC_SEL: current_input_function_select_r <= reg_wdata[3:0];
          `DPM_OFS_FAN_CTRL: fan_onoff_control_r <= reg_wdata[0];
          // Preset wins over a same-cycle hour tick
          `DPM_OFS_RT_PRESET: runtime_r <= reg_wdata[RT_W-1:0];
          default: ;
        endcase
      end
      reg_rdata <= rdata_nxt;
    end
  end

  // Read data is zero outside the cycle after a read strobe
  always @* begin
    rdata_nxt = 32'h00000000;
    if (reg_rd) begin
      case (reg_addr)
        `DPM_OFS_OPTION: rdata_nxt = {26'h0000000, protection_option_word_r};
        `DPM_OFS_HIST_CLR: rdata_nxt = {31'h00000000, alarm_history_clear_r};
        `DPM_OFS_FB_TIMEOUT: rdata_nxt = {22'h000000, feedback_loss_timeout_r};
        `DPM_OFS_FUNC_SEL: rdata_nxt = {28'h0000000, current_input_function_select_r};
        `DPM_OFS_FAN_CTRL: rdata_nxt = {31'h00000000, fan_onoff_control_r};
        `DPM_OFS_RT_PRESET,
        `DPM_OFS_RUNTIME: rdata_nxt = {{(32-RT_W){1'b0}}, runtime_r};
        `DPM_OFS_STATUS: rdata_nxt = {23'h000000, fan_run, life_warning, overheat_output,
          fan_lock_alarm, output_phase_alarm, input_phase_alarm, feedback_loss_alarm,
          carrier_lower, drive_stop};
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Feedback-loss qualification timer

  assign fb_cond = (current_input_level < `DPM_CUR_MIN) &&
    (current_input_function_select_r == `DPM_SEL_PID_FB) && pid_active &&
    (feedback_loss_timeout_r != 10'h000);

  assign fb_trip = fb_cond && (tenths_r == feedback_loss_timeout_r);

  // Next state of the 0.1 s prescaler and the tenths counter
  always @* begin
    tenth_cnt_nxt = tenth_cnt_r;
    tenths_nxt = tenths_r;
    if (!fb_cond) begin
      tenth_cnt_nxt = 32'h00000000;
      tenths_nxt = 10'h000;
    end else if (tenths_r != feedback_loss_timeout_r) begin
      if (tenth_cnt_r == TENTH_S_CYC - 1) begin
        tenth_cnt_nxt = 32'h00000000;
        tenths_nxt = tenths_r + 10'h001;
      end else begin
        tenth_cnt_nxt = tenth_cnt_r + 32'h00000001;
      end
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tenth_cnt_r <= 32'h00000000;
      tenths_r <= 10'h000;
    end else begin
      tenth_cnt_r <= tenth_cnt_nxt;
      tenths_r <= tenths_nxt;
    end
  end

  // Alarm latches until the history clear command; a detection in the
  // clear cycle wins so that a live fault is never wiped out
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      feedback_loss_alarm <= 1'b0;
    end else if (fb_trip) begin
      feedback_loss_alarm <= 1'b1;
    end else if (history_clear) begin
      feedback_loss_alarm <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Protection options and fan lock

  // Lock is masked while the fan is stopped on purpose
  assign fan_lock_seen = fan_locked_raw && fan_run;
  assign in_phase_set = protection_option_word_r[`DPM_OPT_IN_PHASE] &&
    input_phase_loss;
  assign out_phase_set = protection_option_word_r[`DPM_OPT_OUT_PHASE] && run_cmd &&
    output_phase_loss;
  assign fan_lock_set = !protection_option_word_r[`DPM_OPT_FAN_CONT] &&
    fan_lock_seen;

  // Fan follows on/off control only when enabled; a run forces it on
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fan_run <= 1'b1;
    end else begin
      fan_run <= !(fan_onoff_control_r && fan_stop_wanted && !run_cmd);
    end
  end

  // Carrier lowering and capacitor-life controls
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      carrier_lower <= 1'b0;
      cap_user_crit <= 1'b0;
      cap_judge_en <= 1'b0;
    end else begin
      carrier_lower <= protection_option_word_r[`DPM_OPT_CARRIER] &&
        (heatsink_hot || overload);
      cap_user_crit <= protection_option_word_r[`DPM_OPT_CAP_USER];
      cap_judge_en <= protection_option_word_r[`DPM_OPT_CAP_JUDGE] && power_off;
    end
  end

  // Warnings ignore the fan-lock response setting
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      overheat_output <= 1'b0;
      life_warning <= 1'b0;
    end else begin
      overheat_output <= fan_lock_seen;
      life_warning <= fan_lock_seen ||
        (protection_option_word_r[`DPM_OPT_CAP_JUDGE] && power_off && discharge_short);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Sticky trips; as above, a detection beats a same-cycle clear

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      input_phase_alarm <= 1'b0;
    end else if (in_phase_set) begin
      input_phase_alarm <= 1'b1;
    end else if (history_clear) begin
      input_phase_alarm <= 1'b0;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      output_phase_alarm <= 1'b0;
    end else if (out_phase_set) begin
      output_phase_alarm <= 1'b1;
    end else if (history_clear) begin
      output_phase_alarm <= 1'b0;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fan_lock_alarm <= 1'b0;
    end else if (fan_lock_set) begin
      fan_lock_alarm <= 1'b1;
    end else if (history_clear) begin
      fan_lock_alarm <= 1'b0;
    end
  end

  // Stop commands lag the alarms by one cycle
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      drive_stop <= 1'b0;
      coast_stop <= 1'b0;
    end else begin
      drive_stop <= input_phase_alarm || output_phase_alarm || fan_lock_alarm ||
        feedback_loss_alarm;
      coast_stop <= fan_lock_alarm;
    end
  end

endmodule // dpm_top
`default_nettype wire

/* tb/dpm_monitor.sv */
// Checker on the protection block ports.
// Assumes one clock and reset_n asynchronous low.
`default_nettype none
module dpm_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [11:0] current_input_level,
  input wire logic pid_active,
  input wire logic run_cmd,
  input wire logic heatsink_hot,
  input wire logic overload,
  input wire logic input_phase_loss,
  input wire logic output_phase_loss,
  input wire logic fan_locked_raw,
  input wire logic feedback_loss_alarm,
  input wire logic input_phase_alarm,
  input wire logic output_phase_alarm,
  input wire logic fan_lock_alarm,
  input wire logic drive_stop,
  input wire logic coast_stop,
  input wire logic carrier_lower,
  input wire logic overheat_output,
  input wire logic life_warning,
  input wire logic fan_run,
  input wire logic history_clear
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_fb_cause: assert property ($rose(feedback_loss_alarm) |-> $past(pid_active && current_input_level < 12'h0C8))
    else $error("feedback alarm without low current");
  a_inph_cause: assert property ($rose(input_phase_alarm) |-> $past(input_phase_loss))
    else $error("input phase alarm without loss");
  a_outph_cause: assert property ($rose(output_phase_alarm) |-> $past(output_phase_loss && run_cmd))
    else $error("output phase alarm while stopped");
  a_carrier_cause: assert property (carrier_lower |-> $past(heatsink_hot || overload))
    else $error("carrier lowered without stress");
  a_alarm_stop: assert property (input_phase_alarm || output_phase_alarm || fan_lock_alarm |=> drive_stop)
    else $error("alarm without drive stop");
  a_coast_follow: assert property (fan_lock_alarm |=> coast_stop)
    else $error("fan lock alarm without coast");
  a_lock_warn: assert property ((fan_locked_raw && fan_run) [*3] |-> overheat_output && life_warning)
    else $error("fan lock without warnings");
  a_clear_pulse: assert property (history_clear |=> !history_clear)
    else $error("history clear longer than a pulse");
  a_fan_start: assert property (run_cmd [*2] |-> fan_run)
    else $error("fan stopped while running");
  c_fb: cover property ($rose(feedback_loss_alarm));
  c_lock: cover property ($rose(fan_lock_alarm));
  c_clear: cover property (history_clear);
endmodule // dpm_monitor
bind dpm_top dpm_monitor u_mon (.clk(clk), .reset_n(reset_n), .current_input_level(current_input_level),
  .pid_active(pid_active), .run_cmd(run_cmd), .heatsink_hot(heatsink_hot), .overload(overload),
  .input_phase_loss(input_phase_loss), .output_phase_loss(output_phase_loss), .fan_locked_raw(fan_locked_raw),
  .feedback_loss_alarm(feedback_loss_alarm), .input_phase_alarm(input_phase_alarm),
  .output_phase_alarm(output_phase_alarm), .fan_lock_alarm(fan_lock_alarm), .drive_stop(drive_stop),
  .coast_stop(coast_stop), .carrier_lower(carrier_lower), .overheat_output(overheat_output),
  .life_warning(life_warning), .fan_run(fan_run), .history_clear(history_clear));
`default_nettype wire

/* tb/dpm_partner.sv */
// Power stage and sensor stand-in: registers wanted levels.
// Assumes the bench changes want off the clock edge.
`default_nettype none
module dpm_partner (
  input wire logic clk,
  input wire logic [7:0] want,
  output logic [7:0] sense
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge clk) begin
    sense <= want;
  end
endmodule // dpm_partner
`default_nettype wire

/* tb/dpm_top_tb.sv */
// Self-checking bench for the protection block.
// Assumes TENTH_S_CYC cut to 4 cycles per 0.1 s.
`default_nettype none
module dpm_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, pid_active = 1'b0, run_cmd = 1'b0;
  logic fan_stop_wanted = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, seed = 32'hBA24, v;
  logic [11:0] current_input_level = 12'hFFF;
  logic [7:0] want = 8'h00;
  wire [7:0] sense;
  wire [31:0] reg_rdata;
  wire feedback_loss_alarm, input_phase_alarm, output_phase_alarm, fan_lock_alarm, drive_stop, coast_stop;
  wire carrier_lower, overheat_output, life_warning, fan_run, cap_judge_en, cap_user_crit, history_clear;
  int errors = 0, check_count = 0;
  dpm_partner u_part (.clk(clk), .want(want), .sense(sense));
  dpm_top #(.TENTH_S_CYC(4)) u_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .current_input_level(current_input_level),
    .pid_active(pid_active), .run_cmd(run_cmd), .hour_tick(sense[7]), .heatsink_hot(sense[0]), .overload(sense[1]),
    .input_phase_loss(sense[2]), .output_phase_loss(sense[3]), .fan_locked_raw(sense[4]),
    .fan_stop_wanted(fan_stop_wanted), .power_off(sense[5]), .discharge_short(sense[6]),
    .feedback_loss_alarm(feedback_loss_alarm), .input_phase_alarm(input_phase_alarm),
    .output_phase_alarm(output_phase_alarm), .fan_lock_alarm(fan_lock_alarm), .drive_stop(drive_stop),
    .coast_stop(coast_stop), .carrier_lower(carrier_lower), .overheat_output(overheat_output),
    .life_warning(life_warning), .fan_run(fan_run), .cap_judge_en(cap_judge_en), .cap_user_crit(cap_user_crit),
    .history_clear(history_clear));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] opt_exp(input logic [31:0] d);
    return d & 32'h0000003F;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, e);
  endtask
  // Sensor level held 5 cycles, then outputs compared and alarms cleared
  task automatic prot(input logic [31:0] opt, input logic [7:0] w, input logic [8:0] e);
    wr(4'h0, opt);
    want <= w;
    repeat (5) @(posedge clk);
    #1 chk({carrier_lower, input_phase_alarm, output_phase_alarm, fan_lock_alarm, overheat_output, life_warning,
      drive_stop, coast_stop, fan_run}, e);
    want <= 8'h00;
    wr(4'h1, 32'h1);
    repeat (4) @(posedge clk);
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial forever #20 clk = ~clk;
  initial begin
    #400000;
    errors++;
    print_verdict;
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    rd(4'h0, 32'h0);
    rd(4'h9, 32'h0);
    rd(4'h7, 32'h00000100);
    // Power-off sensed so the life judgment enable follows bit 4
    want <= 8'h20;
    for (int i = 0; i < 8; i++) begin
      v = xs();
      wr(4'h0, v);
      wr(4'hA, v);
      rd(4'h0, opt_exp(v));
      chk({cap_judge_en, cap_user_crit}, v[4:3]);
    end
    want <= 8'h00;
    wr(4'h3, 32'h5);
    wr(4'h2, 32'h2);
    pid_active <= 1'b1;
    current_input_level <= 12'(xs() % 200);
    repeat (6) @(posedge clk);
    current_input_level <= 12'h0C8;
    @(posedge clk);
    current_input_level <= 12'h0C7;
    repeat (6) @(posedge clk);
    #1 chk(feedback_loss_alarm, 0);
    repeat (6) @(posedge clk);
    #1 chk(feedback_loss_alarm, 1);
    wr(4'h2, 32'h0);
    wr(4'h1, 32'h1);
    repeat (20) @(posedge clk);
    rd(4'h1, 32'h0);
    chk(feedback_loss_alarm, 0);
    pid_active <= 1'b0;
    wr(4'h2, 32'h3FF);
    rd(4'h2, 32'h258);
    wr(4'h5, 32'h00123456);
    rd(4'h6, 32'h00123456);
    wr(4'h5, 32'h0);
    run_cmd <= 1'b1;
    want <= 8'h80;
    @(posedge clk);
    want <= 8'h00;
    rd(4'h6, 32'h1);
    prot(32'h01, 8'h01, 9'b100000001);
    prot(32'h00, 8'h02, 9'b000000001);
    prot(32'h02, 8'h04, 9'b010000101);
    prot(32'h00, 8'h04, 9'b000000001);
    prot(32'h04, 8'h08, 9'b001000101);
    prot(32'h00, 8'h10, 9'b000111111);
    prot(32'h20, 8'h10, 9'b000011001);
    prot(32'h10, 8'h60, 9'b000001001);
    wr(4'h4, 32'h1);
    run_cmd <= 1'b0;
    fan_stop_wanted <= 1'b1;
    prot(32'h00, 8'h10, 9'b000000000);
    run_cmd <= 1'b1;
    prot(32'h00, 8'h10, 9'b000111111);
    print_verdict;
  end
endmodule // dpm_top_tb
`default_nettype wire
